// ===== rtl/aeps_top.v
/*
  absolute encoder position setup: direction inversion, startup
  acquisition of the encoder absolute position, modulo position and
  position adjustment for encoder 1 and 2.
  assumes: a parameter access port (address, write/read strobes) from the
  fieldbus stack, an encoder front end that delivers the raw absolute
  value on request, and motion control that gives deltas in user units.
*/
// Summary of operation
// - inversion 0 off, 1 negates target direction
// - inversion write refused unless power stage off
// - new inversion takes effect after power-on
// - inversion held persistent, unsigned 16 bit
// - startup reads absolute position from encoder
// - read-only 32-bit position modulo encoder range
// - gear ratio change invalidates modulo until restart
// - singleturn range 131072 increments per turn
// - multiturn range 4096 turns of 131072
// - below zero actual position counts negative
// - power cycle reloads actual from encoder
// - adjust write at standstill sets absolute position
// - adjustment shifts index pulse equally
// - separate adjustment value for encoder 2
// - unshifted range 0..x-1 or 0..4096x-1
// - shifted range -x/2..x/2-1 or +-2048x
// - x is 16384 user units by default
`timescale 1ns/10ps
`default_nettype none
`include "aeps_map.vh"

module aeps_top #(
  parameter USR_PER_REV = 32'h00004000,  // x, user units per turn
  parameter MULTITURN   = 1'b1           // encoder type strap
) (
  input  wire        mclk,
  input  wire        rst_n,
  // parameter access port
  input  wire [15:0] par_addr,
  input  wire [31:0] par_wdata,
  input  wire        par_wr,
  input  wire        par_rd,
  output reg  [31:0] par_rdata,
  output reg         par_ack,
  output reg         par_err,
  // drive state inputs (same clock domain)
  input  wire        power_stage_on,
  input  wire        motor_standstill,
  input  wire        gear_ratio_changed,
  // motion delta in user units, signed, from motion control
  input  wire        move_step,
  input  wire [31:0] move_delta,
  input  wire [31:0] target_in,
  // encoder front end
  output reg         enc_req,
  input  wire        enc_valid,
  input  wire [31:0] enc_abs,
  input  wire        index_in,
  // results
  output reg  [31:0] target_out,
  output reg  [31:0] actual_pos,
  output reg         index_shifted_valid,
  output reg  [31:0] index_offset,
  output reg         dir_inverted
);

  // startup sequencer states, one-hot
  localparam [3:0] S_LOAD = 4'h1;  // fetch persistent words
  localparam [3:0] S_WAIT = 4'h2;  // wait for store read latency
  localparam [3:0] S_ACQ  = 4'h4;  // read encoder absolute value
  localparam [3:0] S_RUN  = 4'h8;  // normal operation

  reg  [3:0]  state;          // sequencer
  reg  [3:0]  next_state;     // next sequencer state
  reg  [1:0]  load_slot;      // slot being fetched at startup
  reg  [1:0]  got_slot;       // slot whose data are on rd_data
  reg         load_phase;     // store read pending
  reg  [15:0] dir_inv_reg;    // written, persistent value
  reg  [31:0] enc1_adj;       // encoder 1 adjustment (signed)
  reg  [31:0] enc2_adj;       // encoder 2 adjustment (signed)
  reg  [15:0] wrs_reg;        // working range shift flag
  reg         wrs_active;     // shift latched at power-on
  reg         mod_valid;      // modulo value still trusted
  reg         refused;        // last write refused (sticky until next adjust, inversion or shift write)
  reg  [31:0] enc_count;      // absolute encoder count in user units
  wire [31:0] span;           // full encoder range in user units
  wire [31:0] half;           // half range for shifted mode
  wire [31:0] modulo;         // encoder_modulo_position
  wire        wr_enc1;        // decoded writes
  wire        wr_enc2;
  wire        wr_dir;
  wire        wr_wrs;
  wire        adj_ok;         // value range check
  wire [31:0] store_rd;       // store read data
  reg  [1:0]  store_raddr;    // store read slot
  reg         store_we;       // store write enable
  reg  [1:0]  store_waddr;    // store write slot
  reg  [31:0] store_wdata;    // store write data
  reg  [31:0] next_count;     // wrapped encoder count

  // full range: x per turn, 4096 turns for multiturn
  assign span = MULTITURN ? (USR_PER_REV * `AEPS_MT_REVS) : USR_PER_REV;
  assign half = {1'b0, span[31:1]};

  assign wr_enc1 = par_wr && (par_addr == `AEPS_ADDR_ENC1_ADJ);
  assign wr_enc2 = par_wr && (par_addr == `AEPS_ADDR_ENC2_ADJ);
  assign wr_dir  = par_wr && (par_addr == `AEPS_ADDR_DIR_INV);
  assign wr_wrs  = par_wr && (par_addr == `AEPS_ADDR_WRS);

  // accepted adjustment range depends on shift
  assign adj_ok = wrs_active ?
                  ($signed(par_wdata) >= -$signed(half)) && ($signed(par_wdata) < $signed(half)) :
                  (par_wdata < span);

  // modulo of actual position into encoder range, as unsigned
  assign modulo = enc_count;

  aeps_store #(
    .WIDTH (32),
    .ABITS (2)
  ) u_store (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (store_we),
    .wr_addr (store_waddr),
    .wr_data (store_wdata),
    .rd_addr (store_raddr),
    .rd_data (store_rd)
  );

  // next sequencer state
  always @* begin
    next_state = state;
    case (state)
      S_LOAD: next_state = S_WAIT;
      S_WAIT: next_state = (got_slot == `AEPS_SLOT_WRS && !load_phase) ? S_ACQ : S_WAIT;
      S_ACQ:  next_state = enc_valid ? S_RUN : S_ACQ;
      S_RUN:  next_state = S_RUN;
      default: next_state = S_LOAD;
    endcase
  end

  // wrapped next encoder count: keeps inside 0..span-1
  always @* begin
    next_count = enc_count + move_delta;
    if (move_delta[31] && (enc_count < (~move_delta + `AEPS_ONE32))) begin
      next_count = enc_count + move_delta + span;  // underrun wraps
    end else if (!move_delta[31] && (next_count >= span)) begin
      next_count = next_count - span;              // overrun wraps
    end
  end

  // persistent store write path: parameter writes that were accepted
  always @* begin
    store_we    = 1'b0;
    store_waddr = `AEPS_SLOT_ENC1;
    store_wdata = par_wdata;
    store_raddr = load_slot;
    if (state == S_RUN) begin
      if (wr_enc1 && motor_standstill && adj_ok) begin
        store_we    = 1'b1;
        store_waddr = `AEPS_SLOT_ENC1;
      end else if (wr_enc2 && motor_standstill && adj_ok) begin
        store_we    = 1'b1;
        store_waddr = `AEPS_SLOT_ENC2;
      end else if (wr_dir && !power_stage_on) begin
        store_we    = 1'b1;
        store_waddr = `AEPS_SLOT_DIRINV;
        store_wdata = {16'h0000, par_wdata[15:0]};
      end else if (wr_wrs && !power_stage_on) begin
        store_we    = 1'b1;
        store_waddr = `AEPS_SLOT_WRS;
        store_wdata = {16'h0000, par_wdata[15:0]};
      end
    end
  end

  // sequencer, startup load and acquisition
  always @(posedge mclk) begin
    if (!rst_n) begin
      state       <= S_LOAD;
      load_slot   <= `AEPS_SLOT_ENC1;
      got_slot    <= `AEPS_SLOT_ENC1;
      load_phase  <= 1'b0;
      dir_inv_reg <= `AEPS_DIR_INV_RST;
      enc1_adj    <= `AEPS_ZERO32;
      enc2_adj    <= `AEPS_ZERO32;
      wrs_reg     <= 16'h0000;
      wrs_active  <= 1'b0;
      dir_inverted <= 1'b0;
      enc_req     <= 1'b0;
      enc_count   <= `AEPS_ZERO32;
      actual_pos  <= `AEPS_ZERO32;
      mod_valid   <= 1'b0;
      index_offset <= `AEPS_ZERO32;
      index_shifted_valid <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        S_LOAD: begin
          load_phase <= 1'b1;  // read of slot 0 issued
        end
        S_WAIT: begin
          // one read per two cycles; data land a cycle after address
          if (load_phase) begin
            load_phase <= 1'b0;
            got_slot   <= load_slot;
          end else begin
            case (got_slot)
              `AEPS_SLOT_ENC1:   enc1_adj <= store_rd;
              `AEPS_SLOT_ENC2:   enc2_adj <= store_rd;
              `AEPS_SLOT_DIRINV: dir_inv_reg <= store_rd[15:0];
              default:           wrs_reg <= store_rd[15:0];
            endcase
            if (got_slot == `AEPS_SLOT_WRS) begin
              // power-on latching of inversion and shift
              dir_inverted <= dir_inv_reg[0];
              wrs_active   <= store_rd[0];
              enc_req      <= 1'b1;
            end else begin
              load_slot  <= load_slot + 2'h1;
              load_phase <= 1'b1;
            end
          end
        end
        S_ACQ: begin
          // actual position rebuilt from encoder, not old count
          if (enc_valid) begin
            enc_req    <= 1'b0;
            enc_count  <= enc_abs;
            actual_pos <= wrs_active && (enc_abs >= half) ? enc_abs - span : enc_abs;
            mod_valid  <= 1'b1;
          end
        end
        S_RUN: begin
          if (move_step) begin
            enc_count  <= next_count;
            actual_pos <= actual_pos + move_delta;  // keeps counting below 0
          end
          if (gear_ratio_changed) begin
            mod_valid <= 1'b0;
          end
          // adjustment only at standstill, in range
          if (wr_enc1 && motor_standstill && adj_ok) begin
            enc1_adj     <= par_wdata;
            index_offset <= par_wdata - actual_pos; // index moves with it
            actual_pos   <= par_wdata;
            enc_count    <= par_wdata[31] ? par_wdata + span : par_wdata;
            index_shifted_valid <= 1'b1;
          end
          if (wr_enc2 && motor_standstill && adj_ok) begin
            enc2_adj <= par_wdata;                  // independent value
          end
          if (wr_dir && !power_stage_on) begin
            dir_inv_reg <= par_wdata[15:0];         // stored, not applied
          end
          if (wr_wrs && !power_stage_on) begin
            wrs_reg <= par_wdata[15:0];
          end
        end
        default: begin
          enc_req <= 1'b0;
        end
      endcase
    end
  end

  // target sign follows latched inversion
  always @(posedge mclk) begin
    if (!rst_n) begin
      target_out <= `AEPS_ZERO32;
    end else begin
      target_out <= dir_inverted ? (~target_in + `AEPS_ONE32) : target_in;
    end
  end

  // parameter access answer: one cycle after strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      par_rdata <= `AEPS_ZERO32;
      par_ack   <= 1'b0;
      par_err   <= 1'b0;
      refused   <= 1'b0;
    end else begin
      par_ack <= (par_wr || par_rd) && (state == S_RUN);
      par_err <= 1'b0;
      if (par_rd && state == S_RUN) begin
        case (par_addr)
          `AEPS_ADDR_ENC1_ADJ: par_rdata <= enc1_adj;
          `AEPS_ADDR_ENC2_ADJ: par_rdata <= enc2_adj;
          `AEPS_ADDR_DIR_INV:  par_rdata <= {16'h0000, dir_inv_reg};
          `AEPS_ADDR_WRS:      par_rdata <= {16'h0000, wrs_reg};
          `AEPS_ADDR_MOD_POS:  par_rdata <= modulo;
          `AEPS_ADDR_STATUS:   par_rdata <= {28'h0000000, refused, dir_inverted,
                                             1'b1, mod_valid};
          default: begin
            par_rdata <= `AEPS_ZERO32;
            par_err   <= 1'b1;                                   // unmapped
          end
        endcase
        // invalid modulo value flagged as error on read
        if (par_addr == `AEPS_ADDR_MOD_POS && (!mod_valid || gear_ratio_changed)) begin
          par_err <= 1'b1;
        end
      end
      if (par_wr && state == S_RUN) begin
        case (par_addr)
          `AEPS_ADDR_ENC1_ADJ,
          `AEPS_ADDR_ENC2_ADJ: begin
            refused <= !(motor_standstill && adj_ok);
            par_err <= !(motor_standstill && adj_ok);
          end
          `AEPS_ADDR_DIR_INV,
          `AEPS_ADDR_WRS: begin
            refused <= power_stage_on;
            par_err <= power_stage_on;
          end
          default: begin
            par_err <= 1'b1;  // read-only or unmapped
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ===== rtl/aeps_map.vh
/*
  register offsets, field positions, reset values and counts for the
  absolute encoder position setup block.
  assumes: included by bare name from the rtl files of this block.
*/
`ifndef AEPS_MAP_VH
`define AEPS_MAP_VH

// parameter addresses, as printed (fieldbus parameter numbers)
`define AEPS_ADDR_ENC1_ADJ      16'h052C
`define AEPS_ADDR_DIR_INV       16'h0618
`define AEPS_ADDR_MOD_POS       16'h1E1E
`define AEPS_ADDR_ENC2_ADJ      16'h052E
`define AEPS_ADDR_WRS           16'h0542
`define AEPS_ADDR_STATUS        16'h0600

// reset and default values
`define AEPS_DIR_INV_RST        16'h0000
`define AEPS_ZERO32             32'h00000000
`define AEPS_ONE32              32'h00000001

// encoder geometry
`define AEPS_ST_INCR            32'h00020000
`define AEPS_MT_REVS            32'h00001000
`define AEPS_MT_HALF            32'h00000800
`define AEPS_USR_PER_REV        32'h00004000

// status word bit positions
`define AEPS_ST_MODVALID        0
`define AEPS_ST_ACQUIRED        1
`define AEPS_ST_INV_ACTIVE      2
`define AEPS_ST_REFUSED         3

// memory slots for persistent values
`define AEPS_SLOT_ENC1          2'h0
`define AEPS_SLOT_ENC2          2'h1
`define AEPS_SLOT_DIRINV        2'h2
`define AEPS_SLOT_WRS           2'h3

`endif

// ===== rtl/aeps_store.v
/*
  small persistent parameter store: four words with registered read data.
  assumes: rst_n models power-on; the words are not cleared by it, so
  written values survive a restart, and start as factory zeros.
*/
`timescale 1ns/10ps
`default_nettype none

module aeps_store #(
  parameter WIDTH = 32,
  parameter ABITS = 2
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire             wr_en,
  input  wire [ABITS-1:0] wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [ABITS-1:0] rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:(1<<ABITS)-1];  // word array
  integer         i;                     // factory fill loop index

  // factory contents; reset leaves the words alone so they persist
  initial begin
    for (i = 0; i < (1<<ABITS); i = i + 1) begin
      mem[i] = {WIDTH{1'b0}};
    end
  end

  // write port and registered read port
  always @(posedge mclk) begin
    if (!rst_n) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      // read-during-write returns the old word
      rd_data <= mem[rd_addr];
    end
  end

endmodule

`default_nettype wire

// ===== tb/aeps_props.sv
/*
  port checker for the absolute encoder position setup block.
  assumes: bound into aeps_top, one mclk domain, sync active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module aeps_props #(
  parameter USR_PER_REV = 32'h00004000,
  parameter MULTITURN   = 1'b1
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [15:0] par_addr,
  input wire logic [31:0] par_wdata,
  input wire logic        par_wr,
  input wire logic        par_rd,
  input wire logic        par_ack,
  input wire logic        par_err,
  input wire logic        power_stage_on,
  input wire logic        motor_standstill,
  input wire logic        gear_ratio_changed,
  input wire logic        move_step,
  input wire logic [31:0] move_delta,
  input wire logic [31:0] target_in,
  input wire logic        enc_req,
  input wire logic        enc_valid,
  input wire logic [31:0] target_out,
  input wire logic [31:0] actual_pos,
  input wire logic        dir_inverted
);
  // full encoder span in user units
  localparam [31:0] SPAN = MULTITURN ? USR_PER_REV * 4096 : USR_PER_REV;
  logic [31:0] wd_hold;  // last write data, kept until the answer
  // capture write data so the answer can be tied to it
  always_ff @(posedge mclk) begin
    if (par_wr)
      wd_hold <= par_wdata;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_ack_has_cause: assert property (par_ack |-> $past(par_wr || par_rd)) else $error("ack without strobe");
  a_err_with_ack: assert property (par_err |-> par_ack) else $error("err without ack");
  a_inv_locked:
    assert property (par_wr && par_addr == 16'h0618 && power_stage_on ##1 par_ack |-> par_err) else $error("inv taken");
  a_adj_moving:
    assert property (par_wr && par_addr == 16'h052C && !motor_standstill ##1 par_ack |-> par_err)
      else $error("adjust taken while moving");
  a_adj_range:
    assert property (par_wr && par_addr == 16'h052C && !par_wdata[31] && par_wdata >= SPAN ##1 par_ack |-> par_err)
      else $error("adjust out of range taken");
  a_mod_readonly:
    assert property (par_wr && par_addr == 16'h1E1E ##1 par_ack |-> par_err) else $error("modulo written");
  a_mod_invalid:
    assert property (par_rd && par_addr == 16'h1E1E && gear_ratio_changed ##1 par_ack |-> par_err)
      else $error("modulo valid after gear change");
  a_adj_sets_pos:
    assert property (par_wr && par_addr == 16'h052C ##1 par_ack && !par_err |-> ##[0:1] actual_pos == wd_hold)
      else $error("adjust not applied");
  a_req_held:
    assert property (enc_req && !enc_valid |=> enc_req) else $error("encoder request dropped");
  a_move_count:
    assert property (move_step && !dir_inverted && !par_wr && !$past(par_wr) && !$past(par_wr, 2) && !enc_valid
      |=> actual_pos == $past(actual_pos) + $past(move_delta)) else $error("actual position not counted");
  a_target_map:
    assert property (1 ##1 $stable(dir_inverted) |-> target_out == (dir_inverted ? -$past(target_in) : $past(target_in)))
      else $error("target direction wrong");
  c_refused: cover property (par_ack && par_err);
  c_taken: cover property (par_ack && !par_err);
  c_acquire: cover property (enc_req ##1 enc_valid);
  c_move: cover property (move_step);
endmodule
bind aeps_top aeps_props #(.USR_PER_REV(USR_PER_REV), .MULTITURN(MULTITURN)) i_props (
  .mclk(mclk), .rst_n(rst_n), .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr), .par_rd(par_rd),
  .par_ack(par_ack), .par_err(par_err), .power_stage_on(power_stage_on), .motor_standstill(motor_standstill),
  .gear_ratio_changed(gear_ratio_changed), .move_step(move_step), .move_delta(move_delta), .target_in(target_in),
  .enc_req(enc_req), .enc_valid(enc_valid), .target_out(target_out), .actual_pos(actual_pos),
  .dir_inverted(dir_inverted));
`default_nettype wire

// ===== tb/aeps_enc_model.sv
/*
  absolute encoder model: answers a position request after lat cycles.
  assumes: enc_req is a level held until the answer pulse is seen.
*/
`timescale 1ns/10ps
`default_nettype none
module aeps_enc_model (
  input  wire logic        mclk,
  input  wire logic        enc_req,
  input  wire logic [31:0] abs_pos,
  input  wire logic [3:0]  lat,
  output var  logic        enc_valid,
  output var  logic [31:0] enc_abs
);
  logic [3:0]  cnt;   // wait before answering
  logic        done;  // one answer per request
  logic [31:0] last;  // last value put out
  initial begin
    enc_valid = 1'b0;
    enc_abs = 32'h00000000;
    cnt = 4'h0;
    done = 1'b0;
    last = 32'h00000000;
  end
  // answer once per request; outside the answer the data is junk
  always @(posedge mclk) begin
    enc_valid <= 1'b0;
    enc_abs <= ~last;
    if (!enc_req) begin
      done <= 1'b0;
      cnt <= 4'h0;
    end else if (!done && cnt == lat) begin
      enc_valid <= 1'b1;
      enc_abs <= abs_pos;
      last <= abs_pos;
      done <= 1'b1;
    end else if (!done) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  testbench for aeps_top: parameter port traffic, startup, moves, restarts.
  assumes: default parameters, multiturn encoder, shift off.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {logic err; logic chk; logic [31:0] dat;} aeps_exp_t;
  localparam [31:0] SPAN = 32'h04000000;  // 4096 turns of 16384 units
  logic        mclk = 1'b0, rst_n = 1'b0, par_wr = 1'b0, par_rd = 1'b0, power_stage_on = 1'b0;
  logic        motor_standstill = 1'b1, gear_ratio_changed = 1'b0, move_step = 1'b0, index_in = 1'b0;
  logic [15:0] par_addr = 16'h0000;
  logic [31:0] par_wdata = 32'h0, move_delta = 32'h0, target_in = 32'h0, abs_pos = 32'h0, a0, v, t;
  logic [3:0]  lat = 4'h0;
  wire  [31:0] par_rdata, enc_abs, target_out, actual_pos, index_offset;
  wire         par_ack, par_err, enc_req, enc_valid, index_shifted_valid, dir_inverted;
  aeps_exp_t   expq[$];  // expected answers, oldest first
  aeps_exp_t   cur;
  integer      n_errors = 0, checks = 0, i;
  aeps_top i_dut (.mclk(mclk), .rst_n(rst_n), .par_addr(par_addr), .par_wdata(par_wdata), .par_wr(par_wr),
    .par_rd(par_rd), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err), .power_stage_on(power_stage_on),
    .motor_standstill(motor_standstill), .gear_ratio_changed(gear_ratio_changed), .move_step(move_step),
    .move_delta(move_delta), .target_in(target_in), .enc_req(enc_req), .enc_valid(enc_valid), .enc_abs(enc_abs),
    .index_in(index_in), .target_out(target_out), .actual_pos(actual_pos), .index_shifted_valid(index_shifted_valid),
    .index_offset(index_offset), .dir_inverted(dir_inverted));
  aeps_enc_model i_enc (.mclk(mclk), .enc_req(enc_req), .abs_pos(abs_pos), .lat(lat), .enc_valid(enc_valid),
    .enc_abs(enc_abs));
  always #25 mclk = ~mclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks = checks + 1;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  endtask
  // one parameter access; the answer is judged by the monitor
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e, input logic c,
                     input logic [31:0] x);
    aeps_exp_t n;
    n.err = e;
    n.chk = c;
    n.dat = x;
    @(posedge mclk);
    par_wr <= w;
    par_rd <= !w;
    par_addr <= a;
    par_wdata <= d;
    expq.push_back(n);
    @(posedge mclk);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // power-on: reset, then wait for acquisition to finish
  task automatic boot(input logic [31:0] a, input logic [3:0] l);
    abs_pos <= a;
    lat <= l;
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 60 && enc_req !== 1'b1; i++) @(posedge mclk);
    for (i = 0; i < 60 && enc_req !== 1'b0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk("actual_pos", a, actual_pos);
  endtask
  task automatic print_verdict;
    if (expq.size() != 0)
      n_errors = n_errors + 1;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // monitor: every answer takes the oldest note
  always @(posedge mclk) begin
    if (rst_n && par_ack === 1'b1) begin
      if (expq.size() == 0)
        chk("unexpected ack", 32'h0, 32'h1);
      else begin
        cur = expq.pop_front();
        chk("par_err", {31'h0, cur.err}, {31'h0, par_err});
        if (cur.chk)
          chk("par_rdata", cur.dat, par_rdata);
      end
    end
  end
  // watchdog, far beyond the expected run
  initial begin
    #400000;
    n_errors = n_errors + 1;
    print_verdict();
  end
  initial begin
    a0 = $urandom(94817);
    a0 = $urandom & 32'h03FFFFFF;
    v = ($urandom & 32'h01FFFFFF) + 32'h00000010;  // adjust lands above zero
    boot(a0, 4'h0);
    bus(1'b0, 16'h0618, 32'h0, 1'b0, 1'b1, 32'h0);
    bus(1'b0, 16'h1E1E, 32'h0, 1'b0, 1'b1, a0);
    power_stage_on <= 1'b1;
    bus(1'b1, 16'h0618, 32'h1, 1'b1, 1'b0, 32'h0);
    bus(1'b0, 16'h0618, 32'h0, 1'b0, 1'b1, 32'h0);
    power_stage_on <= 1'b0;
    bus(1'b1, 16'h0618, 32'h1, 1'b0, 1'b0, 32'h0);
    bus(1'b0, 16'h0618, 32'h0, 1'b0, 1'b1, 32'h1);
    chk("dir_inverted", 32'h0, {31'h0, dir_inverted});
    for (i = 0; i < 4; i++) begin
      t = $urandom;
      target_in <= t;
      repeat (2) @(posedge mclk);
      chk("target_out", t, target_out);
    end
    motor_standstill <= 1'b0;
    bus(1'b1, 16'h052C, v, 1'b1, 1'b0, 32'h0);
    chk("actual_pos", a0, actual_pos);
    motor_standstill <= 1'b1;
    bus(1'b1, 16'h052C, SPAN, 1'b1, 1'b0, 32'h0);
    bus(1'b1, 16'h052C, SPAN - 32'h1, 1'b0, 1'b0, 32'h0);
    bus(1'b1, 16'h052C, v, 1'b0, 1'b0, 32'h0);
    chk("actual_pos", v, actual_pos);
    chk("index_shifted_valid", 32'h1, {31'h0, index_shifted_valid});
    chk("index_offset", v - (SPAN - 32'h1), index_offset);
    bus(1'b1, 16'h052E, 32'h5, 1'b0, 1'b0, 32'h0);
    bus(1'b0, 16'h052C, 32'h0, 1'b0, 1'b1, v);
    bus(1'b0, 16'h052E, 32'h0, 1'b0, 1'b1, 32'h5);
    move_step <= 1'b1;  // negative delta takes actual position 5 below zero
    move_delta <= 32'h0 - v - 32'h5;
    @(posedge mclk);
    move_step <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("actual_pos", 32'hFFFFFFFB, actual_pos);
    bus(1'b0, 16'h1E1E, 32'h0, 1'b0, 1'b1, SPAN - 32'h5);
    bus(1'b1, 16'h1E1E, 32'h0, 1'b1, 1'b0, 32'h0);
    bus(1'b0, 16'h0700, 32'h0, 1'b1, 1'b0, 32'h0);
    gear_ratio_changed <= 1'b1;
    bus(1'b0, 16'h1E1E, 32'h0, 1'b1, 1'b0, 32'h0);
    gear_ratio_changed <= 1'b0;
    repeat (20) @(posedge mclk);  // hold after the adjust write before power-off, scaled down
    boot(a0 ^ 32'h00F0F0F0, 4'h7);
    bus(1'b0, 16'h1E1E, 32'h0, 1'b0, 1'b1, a0 ^ 32'h00F0F0F0);
    chk("dir_inverted", 32'h1, {31'h0, dir_inverted});
    bus(1'b0, 16'h0618, 32'h0, 1'b0, 1'b1, 32'h1);
    t = $urandom;
    target_in <= t;
    repeat (2) @(posedge mclk);
    chk("target_out", 32'h0 - t, target_out);
    print_verdict();
  end
endmodule
`default_nettype wire
